// *** inc/pmc_map.vh ***
/*
  constants of the phy management and control pin block: mdio frame
  fields, management register numbers and bits, apb register offsets.
  assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ----------------------------------------------------------------------
// mdio frame
// ----------------------------------------------------------------------
`define PMC_PRE_MIN       6'd32
`define PMC_PRE_SAT       6'd63
`define PMC_OP_READ       2'b10
`define PMC_OP_WRITE      2'b01
`define PMC_ADDR_LAST     4'd9
`define PMC_DATA_LAST     4'd15
`define PMC_TA_LAST       4'd1

// ----------------------------------------------------------------------
// management registers, per channel
// ----------------------------------------------------------------------
`define PMC_MREG_CTRL     5'h00
`define PMC_MREG_STAT     5'h01
`define PMC_MREG_MODE     5'h1D
`define PMC_CTRL_AN_EN    12
`define PMC_CTRL_AN_RST   9
`define PMC_STAT_LINK     2
`define PMC_STAT_AN_ABLE  3
`define PMC_MODE_FIBER    0
`define PMC_AN_EN_RST     1'b1

// ----------------------------------------------------------------------
// apb registers
// ----------------------------------------------------------------------
`define PMC_APB_INT_STAT  8'h00
`define PMC_APB_INT_MASK  8'h04
`define PMC_APB_PIN_STAT  8'h08
`define PMC_APB_CFG       8'h0C
`define PMC_EV_W          9
`define PMC_EV_SIG        0
`define PMC_EV_AN         4
`define PMC_EV_WR         8
`define PMC_PS_AN         0
`define PMC_PS_SIG        4
`define PMC_PS_FIB        8
`define PMC_PS_HIZ        12
`define PMC_STRAP_WAIT    2'd3

`endif

// *** rtl/pmc_mdio_frame.v ***
/*
  mdio frame engine: preamble, start, opcode, addresses, turnaround,
  16 data bits, stepped on each sampled rising mdc edge.
  assumes i_mdc_rise and i_mdio are already synchronised to i_ref_clk,
  and that read data is presented combinationally from o_phyad/o_regad.
*/
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_mdio_frame (
  input  wire        i_ref_clk,
  input  wire        i_nrst,
  input  wire        i_clk_en,
  input  wire        i_mdc_rise,
  input  wire        i_mdio,
  input  wire        i_hit,
  input  wire [15:0] i_rdata,
  output reg  [4:0]  o_phyad,
  output reg  [4:0]  o_regad,
  output reg  [15:0] o_wdata,
  output reg         o_wr,
  output reg         o_drive,
  output reg         o_dout
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_OP    = 3'd2;
  localparam ST_ADDR  = 3'd3;
  localparam ST_TA    = 3'd4;
  localparam ST_DATA  = 3'd5;

  reg [2:0]  state;
  reg [5:0]  pre;
  reg [3:0]  cnt;
  reg [15:0] sh;
  reg        is_read;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state   <= ST_IDLE;
      pre     <= 6'h00;
      cnt     <= 4'h0;
      sh      <= 16'h0000;
      is_read <= 1'b0;
      o_phyad <= 5'h00;
      o_regad <= 5'h00;
      o_wdata <= 16'h0000;
      o_wr    <= 1'b0;
      o_drive <= 1'b0;
      o_dout  <= 1'b1;
    end else if (i_clk_en) begin
      o_wr <= 1'b0;
      if (i_mdc_rise) begin
        case (state)
          ST_IDLE: begin
            if (i_mdio) begin
              if (pre != `PMC_PRE_SAT)
                pre <= pre + 6'd1;
            end else begin
              pre <= 6'h00;
              if (pre >= `PMC_PRE_MIN)
                state <= ST_START;
            end
          end
          ST_START: begin
            cnt   <= 4'h0;
            state <= i_mdio ? ST_OP : ST_IDLE;
          end
          ST_OP: begin
            sh  <= {sh[14:0], i_mdio};
            cnt <= cnt + 4'd1;
            if (cnt == `PMC_TA_LAST) begin
              cnt     <= 4'h0;
              is_read <= ({sh[0], i_mdio} == `PMC_OP_READ);
              if ({sh[0], i_mdio} == `PMC_OP_READ || {sh[0], i_mdio} == `PMC_OP_WRITE)
                state <= ST_ADDR;
              else
                state <= ST_IDLE;
            end
          end
          ST_ADDR: begin
            sh  <= {sh[14:0], i_mdio};
            cnt <= cnt + 4'd1;
            if (cnt == `PMC_ADDR_LAST) begin
              o_phyad <= sh[8:4];
              o_regad <= {sh[3:0], i_mdio};
              cnt     <= 4'h0;
              state   <= ST_TA;
            end
          end
          ST_TA: begin
            cnt <= cnt + 4'd1;
            if (cnt == 4'h0) begin
              // second turnaround bit: drive the zero only when addressed
              o_drive <= is_read & i_hit;
              o_dout  <= 1'b0;
              sh      <= i_rdata;
            end else begin
              o_dout <= sh[15];
              sh     <= {sh[14:0], 1'b0};
              cnt    <= 4'h0;
              state  <= ST_DATA;
            end
          end
          ST_DATA: begin
            cnt <= cnt + 4'd1;
            if (is_read) begin
              o_dout <= sh[15];
              sh     <= {sh[14:0], 1'b0};
            end else begin
              sh <= {sh[14:0], i_mdio};
            end
            if (cnt == `PMC_DATA_LAST) begin
              o_drive <= 1'b0;
              o_dout  <= 1'b1;
              o_wdata <= {sh[14:0], i_mdio};
              o_wr    <= ~is_read;
              state   <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // pmc_mdio_frame

// *** rtl/pmc_sync.v ***
/*
  two-flop synchroniser for a bus of independent levels.
  assumes each bit is a slow level; no word coherence is given.
*/
`timescale 1ns/1ps
module pmc_sync #(
  parameter W = 1
) (
  input  wire         i_ref_clk,
  input  wire         i_nrst,
  input  wire         i_clk_en,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      meta   <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else if (i_clk_en) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // pmc_sync

// *** rtl/pmc_top.v ***
/*
  management and control pin logic of a four channel transceiver:
  mdio slave, autonegotiation enable pin, output 3-state pin,
  fiber signal detect and fiber mode straps, apb register slave with
  sticky status interrupt.
  assumes all pins are asynchronous to i_ref_clk; apb runs on i_ref_clk.
*/
// Contract
// - mdc accepted with no clock relation
// - device drives status with mdc, else releases
// - status change raises the interrupt output
// - enable pin high enables autonegotiation
// - enable pin pulse restarts autonegotiation
// - effective enable is pin and bit 12
// - 3-state pin high floats the mdio and status interrupt outputs
// - signal detect ignored outside fiber mode
// - fiber mode is strap or bit 0
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_top #(
  parameter        NCH      = 4,
  parameter [4:0]  PHY_BASE = 5'h00
) (
  input  wire            i_ref_clk,
  input  wire            i_nrst,
  input  wire            i_clk_en,
  input  wire            i_psel,
  input  wire            i_penable,
  input  wire            i_pwrite,
  input  wire [7:0]      i_paddr,
  input  wire [31:0]     i_pwdata,
  output reg  [31:0]     o_prdata,
  output reg             o_pready,
  output reg             o_pslverr,
  input  wire            i_mdc,
  input  wire            i_mdio_in,
  output reg             o_mdio_out,
  output reg             o_mdio_oe,
  input  wire            i_auto_en,
  input  wire            i_output_hiz_enable,
  input  wire [NCH-1:0]  i_fiber_signal_detect,
  input  wire [NCH-1:0]  i_fiber_mode_strap,
  output reg             o_status_irq,
  output reg             o_status_irq_oe,
  output reg  [NCH-1:0]  o_an_enable,
  output reg  [NCH-1:0]  o_an_restart,
  output reg  [NCH-1:0]  o_fiber_mode,
  output reg  [NCH-1:0]  o_signal_detect
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam SW = 2 * NCH + 4;

  wire [SW-1:0]  sync_q;
  wire           mdc_s;
  wire           mdio_s;
  wire           auto_en_s;
  wire           hiz_s;
  wire [NCH-1:0] fsd_s;
  wire [NCH-1:0] strap_s;

  // mdc is treated as a plain asynchronous level, whatever its source
  pmc_sync #(
    .W (SW)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_clk_en  (i_clk_en),
    .i_async   ({i_fiber_mode_strap, i_fiber_signal_detect, i_output_hiz_enable,
                 i_auto_en, i_mdio_in, i_mdc}),
    .o_sync    (sync_q)
  );

  assign mdc_s     = sync_q[0];
  assign mdio_s    = sync_q[1];
  assign auto_en_s = sync_q[2];
  assign hiz_s     = sync_q[3];
  assign fsd_s     = sync_q[4 +: NCH];
  assign strap_s   = sync_q[4 + NCH +: NCH];

  // ----------------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------------
  reg  mdc_d;
  reg  auto_en_d;
  wire mdc_rise;
  wire an_pin_rise;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      mdc_d     <= 1'b0;
      auto_en_d <= 1'b0;
    end else if (i_clk_en) begin
      mdc_d     <= mdc_s;
      auto_en_d <= auto_en_s;
    end
  end

  assign mdc_rise    = mdc_s & ~mdc_d;
  assign an_pin_rise = auto_en_s & ~auto_en_d;

  // ----------------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------------
  // the synchroniser needs two edges to fill, so the straps are taken late
  reg [1:0]     strap_wait;
  reg [NCH-1:0] strap_q;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      strap_wait <= 2'd0;
      strap_q    <= {NCH{1'b0}};
    end else if (i_clk_en) begin
      if (strap_wait != `PMC_STRAP_WAIT) begin
        strap_wait <= strap_wait + 2'd1;
        strap_q    <= strap_s;
      end
    end
  end

  // ----------------------------------------------------------------------
  // mdio frame engine
  // ----------------------------------------------------------------------
  wire [4:0]  m_phyad;
  wire [4:0]  m_regad;
  wire [15:0] m_wdata;
  wire        m_wr;
  wire        m_drive;
  wire        m_dout;
  reg  [4:0]  cfg_base;
  wire        m_hit;
  wire [1:0]  m_ch;
  reg  [15:0] m_rdata;

  pmc_mdio_frame u_frame (
    .i_ref_clk  (i_ref_clk),
    .i_nrst     (i_nrst),
    .i_clk_en   (i_clk_en),
    .i_mdc_rise (mdc_rise),
    .i_mdio     (mdio_s),
    .i_hit      (m_hit),
    .i_rdata    (m_rdata),
    .o_phyad    (m_phyad),
    .o_regad    (m_regad),
    .o_wdata    (m_wdata),
    .o_wr       (m_wr),
    .o_drive    (m_drive),
    .o_dout     (m_dout)
  );

  // four consecutive addresses, one per channel
  assign m_hit = (m_phyad[4:2] == cfg_base[4:2]);
  assign m_ch  = m_phyad[1:0];

  // ----------------------------------------------------------------------
  // per channel control, fiber mode and signal detect
  // ----------------------------------------------------------------------
  wire [NCH-1:0] ctrl_an_en;
  wire [NCH-1:0] mode_fiber;
  wire [NCH-1:0] fiber_eff;
  wire [NCH-1:0] sig_eff;
  wire [NCH-1:0] an_eff;
  wire [NCH-1:0] rst_req;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
      wire wr_me;
      reg  an_bit;
      reg  fib_bit;

      assign wr_me = m_wr & m_hit & (m_ch == ch);

      // two flops per channel keep each vector bit on a single driver
      always @(posedge i_ref_clk) begin
        if (!i_nrst) begin
          an_bit  <= `PMC_AN_EN_RST;
          fib_bit <= 1'b0;
        end else if (i_clk_en && wr_me) begin
          if (m_regad == `PMC_MREG_CTRL)
            an_bit <= m_wdata[`PMC_CTRL_AN_EN];
          if (m_regad == `PMC_MREG_MODE)
            fib_bit <= m_wdata[`PMC_MODE_FIBER];
        end
      end

      assign ctrl_an_en[ch] = an_bit;
      assign mode_fiber[ch] = fib_bit;

      assign fiber_eff[ch] = strap_q[ch] | mode_fiber[ch];
      assign sig_eff[ch]   = fsd_s[ch] & fiber_eff[ch];
      assign an_eff[ch]    = auto_en_s & ctrl_an_en[ch];
      // restart on a pin pulse or the self clearing register bit
      assign rst_req[ch]   = an_eff[ch] & (an_pin_rise | (wr_me & (m_regad == `PMC_MREG_CTRL) &
                                           m_wdata[`PMC_CTRL_AN_RST]));
    end
  endgenerate

  // management read data for the addressed channel
  always @* begin
    m_rdata = 16'h0000;
    case (m_regad)
      `PMC_MREG_CTRL: begin
        m_rdata[`PMC_CTRL_AN_EN] = ctrl_an_en[m_ch];
      end
      `PMC_MREG_STAT: begin
        m_rdata[`PMC_STAT_LINK]    = sig_eff[m_ch];
        m_rdata[`PMC_STAT_AN_ABLE] = 1'b1;
      end
      `PMC_MREG_MODE: begin
        m_rdata[`PMC_MODE_FIBER] = mode_fiber[m_ch];
      end
      default: begin
        m_rdata = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // status events
  // ----------------------------------------------------------------------
  reg  [NCH-1:0]       sig_d;
  reg  [NCH-1:0]       an_d;
  reg  [`PMC_EV_W-1:0] int_stat;
  reg  [`PMC_EV_W-1:0] int_mask;
  wire [`PMC_EV_W-1:0] events;

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      sig_d <= {NCH{1'b0}};
      an_d  <= {NCH{1'b0}};
    end else if (i_clk_en) begin
      sig_d <= sig_eff;
      an_d  <= an_eff;
    end
  end

  assign events = {m_wr & m_hit, an_eff ^ an_d, sig_eff ^ sig_d};

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  wire        apb_acc;
  wire        apb_wr;
  wire        apb_map;
  reg  [31:0] rd_mux;

  assign apb_acc = i_psel & i_penable & ~o_pready;
  assign apb_wr  = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
  assign apb_map = (i_paddr == `PMC_APB_INT_STAT) | (i_paddr == `PMC_APB_INT_MASK) |
                   (i_paddr == `PMC_APB_PIN_STAT) | (i_paddr == `PMC_APB_CFG);

  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_paddr)
      `PMC_APB_INT_STAT: rd_mux[`PMC_EV_W-1:0] = int_stat;
      `PMC_APB_INT_MASK: rd_mux[`PMC_EV_W-1:0] = int_mask;
      `PMC_APB_PIN_STAT: begin
        rd_mux[`PMC_PS_AN  +: NCH] = an_eff;
        rd_mux[`PMC_PS_SIG +: NCH] = sig_eff;
        rd_mux[`PMC_PS_FIB +: NCH] = fiber_eff;
        rd_mux[`PMC_PS_HIZ]        = hiz_s;
      end
      `PMC_APB_CFG:      rd_mux[4:0] = cfg_base;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else if (i_clk_en) begin
      o_pready  <= apb_acc;
      o_pslverr <= apb_acc & ~apb_map;
      if (apb_acc && !i_pwrite)
        o_prdata <= rd_mux;
      else if (apb_acc)
        o_prdata <= 32'h0000_0000;
    end
  end

  // sticky status: a new event beats a same cycle write-one-to-clear
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      int_stat <= {`PMC_EV_W{1'b0}};
      int_mask <= {`PMC_EV_W{1'b0}};
      cfg_base <= PHY_BASE;
    end else if (i_clk_en) begin
      if (apb_wr && i_paddr == `PMC_APB_INT_STAT)
        int_stat <= (int_stat & ~i_pwdata[`PMC_EV_W-1:0]) | events;
      else
        int_stat <= int_stat | events;
      if (apb_wr && i_paddr == `PMC_APB_INT_MASK)
        int_mask <= i_pwdata[`PMC_EV_W-1:0];
      if (apb_wr && i_paddr == `PMC_APB_CFG)
        cfg_base <= i_pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      o_mdio_out      <= 1'b1;
      o_mdio_oe       <= 1'b0;
      o_status_irq    <= 1'b0;
      o_status_irq_oe <= 1'b0;
      o_an_enable     <= {NCH{1'b0}};
      o_an_restart    <= {NCH{1'b0}};
      o_fiber_mode    <= {NCH{1'b0}};
      o_signal_detect <= {NCH{1'b0}};
    end else if (i_clk_en) begin
      o_mdio_out      <= m_dout;
      o_mdio_oe       <= m_drive & ~hiz_s;
      o_status_irq    <= |(int_stat & int_mask);
      o_status_irq_oe <= ~hiz_s;
      o_an_enable     <= an_eff;
      o_an_restart    <= rst_req;
      o_fiber_mode    <= fiber_eff;
      o_signal_detect <= sig_eff;
    end
  end

endmodule // pmc_top

// *** sim/pmc_mdio_mgr.sv ***
/*
  behavioural station manager: makes mdc, drives control bits, samples
  the shared data line.
  assumes the bench resolves the wire with a pull-up.
*/
`timescale 1ns/1ps
module pmc_mdio_mgr (
  output logic      o_mdc,
  output logic      o_mdo,
  output logic      o_mdo_en,
  input  wire logic i_mdio
);
  // 800 ns period keeps under both rate ceilings even without a reference
  localparam int HALF = 400;
  initial begin
    o_mdc = 1'b0;
    o_mdo = 1'b1;
    o_mdo_en = 1'b0;
  end
  // bit changes while mdc is low, sampled on the rise
  task automatic bit_io(input logic b, input logic en, output logic s);
    o_mdo_en = en;
    o_mdo = b;
    #HALF o_mdc = 1'b1;
    s = i_mdio;
    #HALF o_mdc = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [31:0] smp);
    logic [31:0] f;
    logic        s;
    integer      i;
    f = {2'b01, rd ? 2'b10 : 2'b01, phy, rg, 2'b10, wd};
    #37; // phase unrelated to the reference clock
    for (i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
    for (i = 31; i >= 0; i--) begin
      bit_io(f[i], !rd || i >= 18, s);
      smp[i] = s;
    end
    o_mdo_en = 1'b0;
  endtask
endmodule // pmc_mdio_mgr

// *** sim/pmc_top_asserts.sv ***
/*
  concurrent checks on the pin and bus ports of the management block.
  assumes one clock domain with a synchronous active low reset.
*/
`timescale 1ns/1ps
module pmc_top_asserts #(
  parameter NCH = 4
) (
  input wire           i_ref_clk,
  input wire           i_nrst,
  input wire           i_psel,
  input wire           i_penable,
  input wire           i_pwrite,
  input wire           o_pready,
  input wire           o_mdio_out,
  input wire           o_mdio_oe,
  input wire           i_auto_en,
  input wire           i_output_hiz_enable,
  input wire [NCH-1:0] i_fiber_mode_strap,
  input wire           o_status_irq,
  input wire           o_status_irq_oe,
  input wire [NCH-1:0] o_an_enable,
  input wire [NCH-1:0] o_an_restart,
  input wire [NCH-1:0] o_fiber_mode,
  input wire [NCH-1:0] o_signal_detect
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  property p_apb_answer;
    i_psel && i_penable && !o_pready |=> o_pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus answer late");
  property p_hiz_float;
    i_output_hiz_enable [*6] |-> !o_mdio_oe && !o_status_irq_oe;
  endproperty
  a_hiz_float: assert property (p_hiz_float) else $error("output driven while floating");
  property p_sd_gated;
    (o_signal_detect & ~o_fiber_mode) == 0;
  endproperty
  a_sd_gated: assert property (p_sd_gated) else $error("detect outside fiber mode");
  property p_strap_or;
    $rose(i_nrst) |-> ##8 ((o_fiber_mode & i_fiber_mode_strap) == i_fiber_mode_strap);
  endproperty
  a_strap_or: assert property (p_strap_or) else $error("strap not in fiber mode");
  property p_an_off;
    !i_auto_en [*6] |-> o_an_enable == 0;
  endproperty
  a_an_off: assert property (p_an_off) else $error("enable without pin");
  property p_restart_pulse;
    |o_an_restart |=> o_an_restart == 0;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
  property p_restart_cause;
    |o_an_restart |-> $past(i_auto_en, 2) && ((o_an_restart & ~o_an_enable) == 0);
  endproperty
  a_restart_cause: assert property (p_restart_cause) else $error("restart without enable");
  property p_irq_clear;
    $fell(o_status_irq) |-> $past(o_pready && i_pwrite) || $past(o_pready && i_pwrite, 2);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt fell unasked");
  property p_ta_low;
    $rose(o_mdio_oe) |-> !o_mdio_out ##1 o_mdio_oe [*7];
  endproperty
  a_ta_low: assert property (p_ta_low) else $error("turnaround bit wrong");
endmodule // pmc_top_asserts

bind pmc_top pmc_top_asserts #(.NCH(NCH)) u_pmc_top_asserts (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .o_pready(o_pready), .o_mdio_out(o_mdio_out), .o_mdio_oe(o_mdio_oe), .i_auto_en(i_auto_en),
  .i_output_hiz_enable(i_output_hiz_enable), .i_fiber_mode_strap(i_fiber_mode_strap),
  .o_status_irq(o_status_irq), .o_status_irq_oe(o_status_irq_oe), .o_an_enable(o_an_enable),
  .o_an_restart(o_an_restart), .o_fiber_mode(o_fiber_mode), .o_signal_detect(o_signal_detect));

// *** sim/pmc_top_tb_top.sv ***
/*
  self-checking bench of the management and control pin block.
  assumes the mdio manager model and a 10 mhz reference clock.
*/
`timescale 1ns/1ps
module pmc_top_tb_top;
  logic        clk, nrst, psel, pen, pwr, ae, hiz, clr;
  logic        pready, pslverr, mdo, mdo_en, mdc, mdio_out, mdio_oe, irq, irq_oe;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  sd, st, fm, ctl, an, anr, fmode, sdet, seen;
  logic [32:0] exp_q[$];
  integer      bad_count, num_checks, cyc, ch;
  // released line floats high on its pull-up
  wire         mdio = mdio_oe ? mdio_out : (mdo_en ? mdo : 1'b1);
  wire [3:0]   fib  = st | fm;

  pmc_top u_pmc_top (
    .i_ref_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_mdc(mdc), .i_mdio_in(mdio), .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe), .i_auto_en(ae),
    .i_output_hiz_enable(hiz), .i_fiber_signal_detect(sd), .i_fiber_mode_strap(st),
    .o_status_irq(irq), .o_status_irq_oe(irq_oe), .o_an_enable(an), .o_an_restart(anr),
    .o_fiber_mode(fmode), .o_signal_detect(sdet));
  pmc_mdio_mgr u_pmc_mdio_mgr (.o_mdc(mdc), .o_mdo(mdo), .o_mdo_en(mdo_en), .i_mdio(mdio));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // bus answers against notes in order, restart pulses gathered
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seen <= (ae && !clr) ? (seen | anr) : 4'h0;
    if (pready === 1'b1) cmp({pslverr, prdata}, exp_q.pop_front());
    if (cyc == 20000) begin
      bad_count++;
      print_verdict;
    end
  end
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the cycle ceiling ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic pins;
    rd(8'h08, {19'h0, hiz, fib, sd & fib, ae ? ctl : 4'h0});
  endtask
  task automatic outs(input logic eirq, input logic [3:0] eseen);
    cmp({15'h0, irq, irq_oe, an, seen, fmode, sdet},
        {15'h0, eirq, !hiz, ae ? ctl : 4'h0, eseen, fib, sd & fib});
  endtask
  task automatic mw(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    u_pmc_mdio_mgr.frame(1'b0, phy, rg, d, v);
  endtask
  task automatic mr(input logic [4:0] phy, input logic [4:0] rg, input logic [16:0] e);
    u_pmc_mdio_mgr.frame(1'b1, phy, rg, 16'h0, v);
    cmp({16'h0, v[16:0]}, {16'h0, e});
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    v = $urandom(85);
    st = v[3:0] | 4'h1;
    sd = v[7:4];
    {nrst, psel, pen, pwr, ae, hiz, clr} = 7'h0;
    {paddr, pwdata, fm, ctl} = {40'h0, 4'h0, 4'hF};
    {cyc, bad_count, num_checks} = {32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tick(10);
    rd(8'h04, 32'h0);
    rd(8'h0C, 32'h0);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, {1'b1, 32'h0});
    rd(8'h00, {28'h0, sd & st});
    pins;
    wr(8'h00, 32'h1FF);
    wr(8'h04, 32'h1FF);
    rd(8'h04, 32'h1FF);
    sd <= ~sd;
    tick(10);
    outs(1'b1, 4'h0);
    rd(8'h00, {28'h0, st});
    wr(8'h00, 32'h1FF);
    tick(3);
    outs(1'b0, 4'h0);
    wr(8'h04, 32'h0);
    sd <= ~sd;
    tick(10);
    outs(1'b0, 4'h0);
    rd(8'h00, {28'h0, st});
    wr(8'h00, 32'h1FF);
    wr(8'h04, 32'h1FF);
    ae <= 1'b1;
    tick(10);
    outs(1'b1, 4'hF);
    rd(8'h00, 32'h0F0);
    wr(8'h00, 32'h1FF);
    pins;
    for (ch = 0; ch < 4; ch++) begin
      v = $urandom;
      ctl[ch] = v[0];
      mw(ch[4:0], 5'd0, {3'h0, ctl[ch], 12'h0});
      mr(ch[4:0], 5'd0, {4'h0, ctl[ch], 12'h0});
    end
    tick(10);
    rd(8'h00, {23'h0, 1'b1, ~ctl, 4'h0});
    wr(8'h00, 32'h1FF);
    ae <= 1'b0;
    tick(10);
    outs(|ctl, 4'h0);
    ae <= 1'b1;
    tick(10);
    outs(|ctl, ctl);
    // restart through the self clearing control bit, channel 0 only
    clr <= 1'b1;
    tick(2);
    clr <= 1'b0;
    mw(5'd0, 5'd0, {3'h0, ctl[0], 2'h0, 1'b1, 9'h0});
    tick(10);
    outs(1'b1, {3'h0, ctl[0]});
    wr(8'h00, 32'h1FF);
    mw(5'd3, 5'd29, 16'h0001);
    fm[3] = 1'b1;
    tick(10);
    outs(1'b1, {3'h0, ctl[0]});
    mr(5'd3, 5'd29, 17'h1);
    mr(5'd3, 5'd1, {13'h0, 1'b1, sd[3], 2'h0});
    mr(5'd8, 5'd0, 17'h1_FFFF);
    pins;
    wr(8'h00, 32'h1FF);
    hiz <= 1'b1;
    tick(10);
    outs(1'b0, {3'h0, ctl[0]});
    pins;
    mr(5'd0, 5'd0, 17'h1_FFFF);
    hiz <= 1'b0;
    tick(10);
    outs(1'b0, {3'h0, ctl[0]});
    print_verdict;
  end
endmodule // pmc_top_tb_top
